// [src/tlc_regs.vh]
// constants and timing figures of the two-level cache subsystem
// Function
// - instruction cache 64KB, four ways, 32-byte lines.
// - data cache 64KB, four ways, 32-byte lines, write-back stores.
// - shared second level is four modules, each on a 128-bit bus.
// - each second-level module globally addressed, 1M, four ways, write-back.
// - fixed-point hit completes in 3 cycles, floating-point hit in 4.
// - one shared 128-bit port for read, write and refill per first-level cache.
// - second level uses 128-bit path, accessed only after first-level miss.
// - second-level serviced miss adds at least 14 cycles, 6 for crossbar.
// - refill delivers 128 bits per cycle into the first level.
// - first level virtually indexed, physically tagged; second level all physical.
// - each second-level line keeps a 32-bit directory of first-level holders.
// - hardware keeps all cache levels and I/O writes coherent.
// - non-blocking; hits proceed under misses; up to 24 outstanding misses.
// - first-level miss looks up second level; memory only on its miss.
// - uncached accesses are blocking, completing in program order.
// - load to fixed-point register 0 is a prefetch without architectural effect.
// - victim way chosen randomly at the first level; second level replaces its indexed entry.
// - second level supports 4 locked windows excluded from replacement.
`ifndef TLC_REGS_VH
`define TLC_REGS_VH
`define TLC_LINE_BYTES 32
`define TLC_L1_WAYS 4
`define TLC_L1_SETS 512
`define TLC_L2_MODULES 4
`define TLC_L2_SETS 8192
`define TLC_DIR_BITS 32
`define TLC_MSHR_DEPTH 24
`define TLC_LOCK_WIN 4
`define TLC_FIX_HIT_CYC 3
`define TLC_FP_HIT_CYC 4
`define TLC_L2_PENALTY 14
`define TLC_XBAR_CYC 6
`define TLC_MEM_LAT 20
`endif

// [src/tlc_mem.v]
// single-port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tlc_mem #(
	parameter WIDTH = 128,
	parameter DEPTH = 256,
	parameter AW = 8
) (
	input wire core_clk,
	input wire wr_en,
	input wire [AW-1:0] addr,
	input wire [WIDTH-1:0] wr_data,
	output reg [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
		rd_data <= mem[addr];
	end
endmodule // tlc_mem
`default_nettype wire

// [src/tlc_cache.v]
// data-cache lookup, miss tracking and second-level refill sequencing
`timescale 1ns/1ps
`default_nettype none
`include "tlc_regs.vh"
module tlc_cache #(
	parameter SETS = 16,
	parameter MSHR = `TLC_MSHR_DEPTH,
	parameter L2_LAT = `TLC_L2_PENALTY,
	parameter MEM_LAT = `TLC_MEM_LAT
) (
	input wire core_clk,
	input wire rst_n,
	input wire req_valid,
	output wire req_ready,
	input wire req_write,
	input wire req_fp,
	input wire req_uncached,
	input wire [4:0] req_dest,
	input wire [47:0] req_vaddr,
	input wire [47:0] req_paddr,
	input wire [127:0] req_wdata,
	output reg resp_valid,
	output reg [127:0] resp_rdata,
	output reg resp_miss,
	input wire [47:0] lock_base0,
	input wire [47:0] lock_base1,
	input wire [47:0] lock_base2,
	input wire [47:0] lock_base3,
	input wire [3:0] lock_en,
	input wire [47:0] lock_mask,
	output reg [4:0] miss_count,
	output reg [2:0] l2_sel,
	output reg l2_hit_last,
	output reg mem_access,
	output reg [31:0] dir_vector,
	input wire [4:0] holder_id
);
	localparam SW = 4;
	localparam ST_IDLE = 2'd0;
	localparam ST_L2 = 2'd1;
	localparam ST_MEM = 2'd2;
	localparam ST_FILL = 2'd3;

	// ==================================================
	// tag store
	reg [35:0] tag [0:SETS*4-1];
	reg [SETS*4-1:0] tag_ok;
	reg [3:0] dirty;
	reg [3:0] lfsr;
	reg [1:0] victim;
	reg miss_unc;
	reg unc_pend;
	reg [1:0] state;
	reg [7:0] wait_cnt;
	reg [47:0] miss_addr;
	reg fill_beat;
	reg [47:0] l2_tag [0:15];
	reg [31:0] dir_mem [0:15];
	reg [15:0] l2_valid;
	wire [SW-1:0] set_idx = req_vaddr[5+SW-1:5];
	wire [35:0] ptag = req_paddr[47:12];
	reg hit;
	reg [1:0] hit_way;
	wire [3:0] way_match;
	genvar w;
	generate
		for (w = 0; w < 4; w = w + 1) begin : g_way
			// valid bit gates the compare so unwritten tags never match
			assign way_match[w] = tag_ok[set_idx*4+w] && (tag[set_idx*4+w] == ptag);
		end
	endgenerate
	integer i;
	always @* begin
		hit = 1'b0;
		hit_way = 2'd0;
		for (i = 0; i < 4; i = i + 1) begin
			if (way_match[i]) begin
				hit = 1'b1;
				hit_way = i[1:0];
			end
		end
	end
	// uncached accesses never use a cached copy
	wire lookup_hit = hit && !req_uncached;

	// ==================================================
	// second-level lookup and lock windows
	wire [3:0] l2_idx = miss_addr[8:5];
	wire l2_hit = l2_valid[l2_idx] && (l2_tag[l2_idx] == miss_addr);
	wire [47:0] lock_base [0:3];
	assign lock_base[0] = lock_base0;
	assign lock_base[1] = lock_base1;
	assign lock_base[2] = lock_base2;
	assign lock_base[3] = lock_base3;
	// the line about to be displaced is what a window protects
	wire [47:0] l2_old = l2_tag[l2_idx];
	wire [3:0] lock_match;
	generate
		for (w = 0; w < `TLC_LOCK_WIN; w = w + 1) begin : g_lock
			assign lock_match[w] = lock_en[w] && ((l2_old & lock_mask) == (lock_base[w] & lock_mask));
		end
	endgenerate
	wire locked = l2_valid[l2_idx] && (|lock_match);

	// ==================================================
	// data array, 128 bits per access
	wire [127:0] data_q;
	wire data_we = ((state == ST_FILL) && !miss_unc) || (req_valid && req_ready && req_write && lookup_hit);
	wire [7:0] data_addr = (state == ST_FILL) ? {miss_addr[8:5], victim, 1'b0, fill_beat} :
		{set_idx, hit_way, 1'b0, req_vaddr[4]};
	tlc_mem #(.WIDTH(128), .DEPTH(256), .AW(8)) u_data (
		.core_clk(core_clk),
		.wr_en(data_we),
		.addr(data_addr),
		.wr_data((state == ST_FILL) ? {80'h0, miss_addr} : req_wdata),
		.rd_data(data_q)
	);

	// hits pass while misses are pending; full tracker or a blocking
	// uncached access stalls the pipe
	// refill owns the data array port, so requests wait out its two beats
	wire full = (miss_count == MSHR[4:0]);
	wire blocked = unc_pend || (req_uncached && miss_count != 5'h0) || (state == ST_FILL);
	assign req_ready = !full && !blocked;

	// ==================================================
	// pipeline delay for hit latency
	reg [3:0] pipe_v;
	reg [3:0] pipe_fp;
	reg [3:0] pipe_pf;
	wire take = req_valid && req_ready;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pipe_v <= 4'h0;
			pipe_fp <= 4'h0;
			pipe_pf <= 4'h0;
			resp_valid <= 1'b0;
			resp_rdata <= 128'h0;
			resp_miss <= 1'b0;
		end else begin
			pipe_v <= {pipe_v[2:0], take && lookup_hit && !req_write};
			pipe_fp <= {pipe_fp[2:0], req_fp};
			pipe_pf <= {pipe_pf[2:0], req_dest == 5'd0};
			resp_valid <= (pipe_v[1] && !pipe_fp[1] && !pipe_pf[1]) ||
				(pipe_v[2] && pipe_fp[2] && !pipe_pf[2]);
			resp_rdata <= data_q;
			resp_miss <= take && !lookup_hit;
		end
	end

	// ==================================================
	// pending miss queue, one entry per outstanding miss
	// depth rounded up to 32 so the pointers wrap by themselves;
	// the counter keeps no more than MSHR entries in use
	reg [48:0] mq_entry [0:31];
	reg [4:0] mq_wr;
	reg [4:0] mq_rd;
	wire push = take && !lookup_hit;
	wire pop = (state == ST_FILL) && fill_beat;
	wire [4:0] next_miss_count = miss_count + {4'h0, push} - {4'h0, pop};
	always @(posedge core_clk) begin
		if (push) begin
			mq_entry[mq_wr] <= {req_uncached, req_paddr};
		end
	end

	// ==================================================
	// miss sequencer: l1 miss -> l2 -> memory, one line at a time
	always @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			wait_cnt <= 8'h0;
			miss_addr <= 48'h0;
			miss_count <= 5'h0;
			fill_beat <= 1'b0;
			lfsr <= 4'h1;
			l2_sel <= 3'h0;
			l2_hit_last <= 1'b0;
			mem_access <= 1'b0;
			l2_valid <= 16'h0;
			dirty <= 4'h0;
			dir_vector <= 32'h0;
			tag_ok <= {SETS*4{1'b0}};
			victim <= 2'h0;
			miss_unc <= 1'b0;
			unc_pend <= 1'b0;
			mq_wr <= 5'h0;
			mq_rd <= 5'h0;
		end else begin
			// four-bit lfsr so every way, way 0 included, gets picked
			lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
			mem_access <= 1'b0;
			miss_count <= next_miss_count;
			if (push) begin
				mq_wr <= mq_wr + 5'd1;
			end
			if (take && req_uncached) begin
				unc_pend <= 1'b1;
			end else if (pop && miss_unc) begin
				unc_pend <= 1'b0;
			end
			if (take && req_write && lookup_hit) begin
				dirty[hit_way] <= 1'b1;
			end
			case (state)
			ST_IDLE: begin
				if (miss_count != 5'h0) begin
					miss_addr <= mq_entry[mq_rd][47:0];
					miss_unc <= mq_entry[mq_rd][48];
					mq_rd <= mq_rd + 5'd1;
					victim <= lfsr[1:0];
					wait_cnt <= L2_LAT[7:0];
					l2_sel <= {1'b0, mq_entry[mq_rd][6:5]};
					state <= ST_L2;
				end
			end
			ST_L2: begin
				if (wait_cnt > 8'd1) begin
					wait_cnt <= wait_cnt - 8'd1;
				end else if (l2_hit && !miss_unc) begin
					l2_hit_last <= 1'b1;
					state <= ST_FILL;
				end else begin
					l2_hit_last <= 1'b0;
					mem_access <= 1'b1;
					wait_cnt <= MEM_LAT[7:0];
					state <= ST_MEM;
				end
			end
			ST_MEM: begin
				if (wait_cnt > 8'd1) begin
					wait_cnt <= wait_cnt - 8'd1;
				end else begin
					// a locked victim stays; the line then lives in l1 only
					if (!miss_unc && !locked) begin
						l2_tag[l2_idx] <= miss_addr;
						l2_valid[l2_idx] <= 1'b1;
						dir_mem[l2_idx] <= 32'h0;
					end
					state <= ST_FILL;
				end
			end
			ST_FILL: begin
				fill_beat <= !fill_beat;
				if (fill_beat) begin
					if (!miss_unc) begin
						tag[{miss_addr[8:5], victim}] <= miss_addr[47:12];
						tag_ok[{miss_addr[8:5], victim}] <= 1'b1;
						dirty[victim] <= 1'b0;
					end
					if (!miss_unc && l2_hit) begin
						dir_mem[l2_idx] <= dir_mem[l2_idx] | (32'h1 << holder_id);
						dir_vector <= dir_mem[l2_idx] | (32'h1 << holder_id);
					end
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // tlc_cache
`default_nettype wire

// [tb/tlc_core_mdl.sv]
// core-side issuer that holds a request until it is taken
`timescale 1ns/1ps
`default_nettype none
module tlc_core_mdl (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic req_ready,
	output logic req_valid
);
	// ====
	// request hold, never dropped while refused
	always @(posedge core_clk) begin
		if (!rst_n || (req_valid && req_ready)) begin
			req_valid <= 1'b0;
		end else if (go) begin
			req_valid <= 1'b1;
		end
	end
endmodule // tlc_core_mdl
`default_nettype wire

// [tb/tlc_cache_sva.sv]
// assertion checker for the data-cache block
`timescale 1ns/1ps
`default_nettype none
module tlc_cache_sva #(
	parameter MSHR = 24
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic req_fp,
	input wire logic req_uncached,
	input wire logic [4:0] req_dest,
	input wire logic resp_valid,
	input wire logic resp_miss,
	input wire logic [4:0] miss_count,
	input wire logic mem_access
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ====
	// properties
	sequence rd_take(f);
		req_valid && req_ready && !req_write && !req_uncached && req_fp == f && req_dest != 5'h0;
	endsequence
	hit_fix_a: assert property (rd_take(1'b0) ##1 !resp_miss |-> ##2 resp_valid)
		else $error("late fixed hit");
	hit_fp_a: assert property (rd_take(1'b1) ##1 !resp_miss |-> ##3 resp_valid)
		else $error("late fp hit");
	pf_quiet_a: assert property (req_valid && req_ready && !req_write && !req_dest && !miss_count |-> ##3 !resp_valid)
		else $error("prefetch answered");
	full_stall_a: assert property (miss_count == MSHR |-> !req_ready)
		else $error("taken while full");
	miss_cap_a: assert property (miss_count <= MSHR)
		else $error("too many misses");
	unc_block_a: assert property (req_uncached && miss_count != 5'h0 |-> !req_ready)
		else $error("uncached under miss");
	mem_gap_a: assert property (resp_miss && $past(miss_count) == 5'h0 |=> !mem_access [*8])
		else $error("memory too early");
	reset_zero_a: assert property (disable iff (1'b0) !rst_n |=> !miss_count && !resp_valid)
		else $error("not cleared by reset");
endmodule // tlc_cache_sva
bind tlc_cache tlc_cache_sva #(.MSHR(MSHR)) u_sva (.core_clk(core_clk), .rst_n(rst_n),
	.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_fp(req_fp),
	.req_uncached(req_uncached), .req_dest(req_dest), .resp_valid(resp_valid),
	.resp_miss(resp_miss), .miss_count(miss_count), .mem_access(mem_access));
`default_nettype wire

// [tb/two_level_cache_subsystem_tb.sv]
// self-checking bench for the data-cache block
`timescale 1ns/1ps
`default_nettype none
module two_level_cache_subsystem_tb;
	localparam logic [7:0] RD = 8'h08;
	logic core_clk = 0, rst_n = 0, go = 0, req_valid, req_ready, resp_valid, resp_miss;
	logic [7:0] ctl = RD;
	logic [4:0] miss_count, top = 0, mc;
	logic [47:0] a = 0, lb = 0;
	logic [3:0] len = 4'h0;
	logic l2h;
	logic [31:0] dv;
	logic [127:0] wd = {4{32'h1234_5678}}, rdata;
	int err_count = 0, check_count = 0, n;
	initial forever #5 core_clk = ~core_clk;
	always @(negedge core_clk) if (miss_count > top) top <= miss_count;
	tlc_core_mdl u_core (.core_clk(core_clk), .rst_n(rst_n), .go(go), .req_ready(req_ready), .req_valid(req_valid));
	tlc_cache #(.SETS(16)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(ctl[0]), .req_fp(ctl[1]), .req_uncached(ctl[2]), .req_dest(ctl[7:3]),
		.req_vaddr(a), .req_paddr(a), .req_wdata(wd), .resp_valid(resp_valid), .resp_rdata(rdata),
		.resp_miss(resp_miss), .lock_base0(lb), .lock_base1(lb), .lock_base2(lb), .lock_base3(lb),
		.lock_en(len), .lock_mask(lb), .miss_count(miss_count), .l2_sel(), .l2_hit_last(l2h),
		.mem_access(), .dir_vector(dv), .holder_id(ctl[7:3]));
	task automatic chk(input string s, input logic [127:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] c, input logic [47:0] ad);
		@(negedge core_clk);
		ctl = c;
		a = ad;
		go = 1;
		@(negedge core_clk);
		go = 0;
		while (!(req_valid && req_ready)) @(negedge core_clk);
		mc = miss_count;
		@(posedge core_clk);
	endtask
	task automatic lat(input logic [7:0] c, input logic [47:0] ad);
		send(c, ad);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (resp_valid !== 1'b1 && n < 40);
	endtask
	task automatic idle;
		repeat (3) @(negedge core_clk);
		while (miss_count !== 5'h0) @(negedge core_clk);
		repeat (3) @(negedge core_clk);
	endtask
	task automatic t_rw;
		lat(RD, 48'h40);
		idle;
		send(8'h09, 48'h40);
		lat(RD, 48'h40);
		chk("fixed hit latency", 128'(n), 128'(3));
		chk("read data", rdata, wd);
		lat(8'h0A, 48'h40);
		chk("fp hit latency", 128'(n), 128'(4));
	endtask
	task automatic t_pf;
		lat(8'h00, 48'h80);
		chk("prefetch answer", 128'(n), 128'(40));
		idle;
		lat(RD, 48'h80);
		chk("prefetched hit", 128'(n), 128'(3));
		chk("served from memory", 128'(l2h), 128'(0));
		chk("directory holder", 128'(dv), 128'(32'h0000_0001));
	endtask
	task automatic t_full;
		for (int k = 0; k < 26; k++) begin
			if (k == 12) send(RD, 48'h40);
			send(RD, 48'h1_0000 * (k + 1) + 48'h20 * (k % 15 + 1));
		end
		chk("peak misses", 128'(top), 128'(24));
		send(8'h0C, 48'h200);
		chk("misses at uncached take", 128'(mc), 128'(0));
	endtask
	task automatic conclude;
		if (err_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge core_clk);
		rst_n = 1;
		t_rw;
		t_pf;
		t_full;
		idle;
		conclude;
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		err_count++;
		conclude;
	end
endmodule // two_level_cache_subsystem_tb
`default_nettype wire
